// File: hdl/ood_decoder.sv
// Decode and execute stage for one slice of the instruction set.
// Assumes the fetch logic presents the instruction with its memory operands
// already read, and holds them until ready_q returns high.
`timescale 1ns/1ns
module ood_decoder (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  // Instruction and operands
  input wire logic instr_valid,
  input wire logic [23:0] instr_word,
  input wire logic [23:0] mem_word,
  input wire logic [23:0] mem_word_hi,
  input wire logic [23:0] fld_a,
  input wire logic [23:0] fld_c,
  // Console and fault clearing
  input wire logic sel_stop_sw,
  input wire logic restart,
  input wire logic float_fault_clr,
  input wire logic dec_fault_clr,
  // Handshake
  output logic ready_q,
  output logic done_q,
  output logic illegal_q,
  output logic halted_q,
  // Arithmetic registers
  output logic [23:0] a_q,
  output logic [23:0] q_q,
  output logic [47:0] e_q,
  output logic [14:0] idx1_q,
  output logic [14:0] idx2_q,
  output logic [14:0] idx3_q,
  output logic [14:0] p_q,
  // State registers and flags
  output logic [2:0] op_state_q,
  output logic [2:0] ins_state_q,
  output logic [5:0] cond_reg_q,
  output logic [2:0] chan_idx_q,
  output logic float_fault_q,
  output logic dec_fault_q,
  output logic int_ctl_q,
  // Character field result
  output logic [23:0] fld_c_sum_q,
  output logic fld_c_wr_q
);
  // ****************************************
  // Declarations
  // ****************************************
  ood_pkg::ood_state_t state_q; // Sequencer
  logic [23:0] ir_q; // Held instruction
  logic [23:0] mem_q; // Held operand M
  logic [23:0] mem_hi_q; // Held operand M+1
  logic [11:0] page_q [ood_pkg::PAGE_DEPTH]; // Page file, no reset
  ood_pkg::ood_fields_t f; // Field view of ir_q
  ood_pkg::ood_op_t op; // Decoded operation
  logic exec; // Execute cycle, enabled
  logic sext; // y is sign extended
  logic [23:0] y_full; // Widened y
  logic [5:0] pidx; // Page file index after offset
  logic [14:0] idx_sel; // Index register chosen by d1
  logic take_jump; // Compare jump condition
  logic take_skip; // Skip condition
  logic [47:0] pair_sum; // AQ plus double word
  // ****************************************
  // Field split and decode
  // ****************************************
  // Sub-digits overlap the address field on purpose; each op reads its own
  assign f.major = ir_q[ood_pkg::MAJ_LSB +: 6];
  assign f.d1 = ir_q[ood_pkg::D1_LSB +: 3];
  assign f.d2 = ir_q[ood_pkg::D2_LSB +: 3];
  assign f.d3 = ir_q[ood_pkg::D3_LSB +: 3];
  assign f.y = ir_q[ood_pkg::ADDR_W-1:0];
  assign f.w = ir_q[ood_pkg::PIDX_W-1:0];
  // Whole pattern is matched before any op is chosen
  always_comb begin
    op = ood_pkg::OP_NONE;
    case (f.major)
      ood_pkg::MAJ_SYS: begin
        case ({f.d1, f.d2})
          ood_pkg::SUB_STPE: op = ood_pkg::OP_STORE_PAGE_ENTRY;
          ood_pkg::SUB_LDPE: op = ood_pkg::OP_LOAD_PAGE_ENTRY;
          ood_pkg::SUB_WRST: begin
            // Third digit picks the instruction state over the operand state
            if (f.d3 == ood_pkg::D_FOUR) op = ood_pkg::OP_WRITE_INSTRUCTION_STATE;
            if (f.d3 == ood_pkg::D_ZERO) op = ood_pkg::OP_WRITE_OPERAND_STATE;
          end
          ood_pkg::SUB_RDST: begin
            if (f.d3 == ood_pkg::D_FOUR) op = ood_pkg::OP_READ_INSTRUCTION_STATE;
            if (f.d3 == ood_pkg::D_ZERO) op = ood_pkg::OP_READ_OPERAND_STATE;
          end
          // Plain 77.63 is another block's opcode
          ood_pkg::SUB_CR: if (f.d3 == ood_pkg::D_FOUR) op = ood_pkg::OP_WRITE_CONDITION_REG;
          ood_pkg::SUB_CHX: op = ood_pkg::OP_WRITE_CHANNEL_INDEX;
          ood_pkg::SUB_SHLT: op = ood_pkg::OP_SELECTIVE_HALT;
          ood_pkg::SUB_FFLT: op = ood_pkg::OP_RAISE_FLOAT_FAULT;
          ood_pkg::SUB_DFLT: op = ood_pkg::OP_RAISE_DECIMAL_FAULT;
          ood_pkg::SUB_IOFF: op = ood_pkg::OP_INTERRUPT_CONTROL_OFF;
          ood_pkg::SUB_ION: op = ood_pkg::OP_INTERRUPT_CONTROL_ON;
          ood_pkg::SUB_UHLT: op = ood_pkg::OP_UNCONDITIONAL_HALT;
          default: op = ood_pkg::OP_NONE;
        endcase
      end
      ood_pkg::MAJ_ADDW: op = ood_pkg::OP_ADD_WORD;
      ood_pkg::MAJ_ADDD: op = ood_pkg::OP_ADD_DOUBLE_WORD;
      ood_pkg::MAJ_CHAR: if (f.d1 == ood_pkg::D_ZERO) op = ood_pkg::OP_ADD_CHAR_FIELD;
      ood_pkg::MAJ_XFER: begin
        if (f.d1 == ood_pkg::D_SIX) op = ood_pkg::OP_ACC_TO_E_UPPER;
        if (f.d1 == ood_pkg::D_SEVEN) op = ood_pkg::OP_PAIR_TO_E;
      end
      ood_pkg::MAJ_RADD: begin
        // b of zero means Q, one to three an index register
        if (f.d2 == ood_pkg::D_FOUR && f.d1 == ood_pkg::D_ZERO) begin
          op = ood_pkg::OP_ADD_Q_TO_ACC;
        end else if (f.d2 == ood_pkg::D_FOUR && f.d1 < ood_pkg::D_FOUR) begin
          op = ood_pkg::OP_ADD_INDEX_TO_ACC;
        end
      end
      ood_pkg::MAJ_CJMP: if (f.d1[2]) op = ood_pkg::OP_COMPARE_JUMP_PAIR;
      ood_pkg::MAJ_AND: begin
        if (f.d1 == ood_pkg::D_SIX || f.d1 == ood_pkg::D_FOUR) begin
          op = ood_pkg::OP_AND_ACC;
        end else if (f.d1[2]) begin
          op = ood_pkg::OP_AND_Q;
        end else if (f.d1 != ood_pkg::D_ZERO) begin
          op = ood_pkg::OP_AND_INDEX;
        end
      end
      // Only the 4 and 6 forms of the skips belong here
      ood_pkg::MAJ_SKEQ: if (f.d1[2] && !f.d1[0]) op = ood_pkg::OP_SKIP_IF_EQUAL;
      ood_pkg::MAJ_SKGE: if (f.d1[2] && !f.d1[0]) op = ood_pkg::OP_SKIP_IF_NOT_LESS;
      default: op = ood_pkg::OP_NONE;
    endcase
  end
  // ****************************************
  // Operand shaping and conditions
  // ****************************************
  assign exec = ce && (state_q == ood_pkg::ST_EXEC);
  // Digits 4 and 5 ask for the extended form, 6 and 7 for the plain one
  assign sext = ~f.d1[1];
  assign y_full = sext ? {{9{f.y[14]}}, f.y} : {9'h000, f.y};
  assign pidx = f.w + idx2_q[5:0];
  assign pair_sum = {a_q, q_q} + {mem_q, mem_hi_q};
  // Index register named by the low two bits of d1
  always_comb begin
    case (f.d1[1:0])
      2'h1: idx_sel = idx1_q;
      2'h2: idx_sel = idx2_q;
      2'h3: idx_sel = idx3_q;
      default: idx_sel = ood_pkg::RST_ADDR;
    endcase
  end
  // Jump tests on A against Q, signed
  always_comb begin
    case (f.d1[1:0])
      2'h0: take_jump = (a_q == q_q);
      2'h1: take_jump = (a_q != q_q);
      2'h2: take_jump = ($signed(a_q) >= $signed(q_q));
      default: take_jump = ($signed(a_q) < $signed(q_q));
    endcase
  end
  assign take_skip = (op == ood_pkg::OP_SKIP_IF_EQUAL) ? (a_q == y_full) :
    ($signed(a_q) >= $signed(y_full));
  // ****************************************
  // Sequencer
  // ****************************************
  // One execute cycle per instruction keeps decode off the fetch path
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ood_pkg::ST_IDLE;
      ready_q <= 1'b1;
      done_q <= 1'b0;
      illegal_q <= 1'b0;
      halted_q <= 1'b0;
      ir_q <= ood_pkg::RST_WORD;
      mem_q <= ood_pkg::RST_WORD;
      mem_hi_q <= ood_pkg::RST_WORD;
    end else if (ce) begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
      case (state_q)
        ood_pkg::ST_IDLE: begin
          // Latch the whole instruction and operands M and M+1 together; fields A and C are not held
          if (instr_valid) begin
            ir_q <= instr_word;
            mem_q <= mem_word;
            mem_hi_q <= mem_word_hi;
            ready_q <= 1'b0;
            state_q <= ood_pkg::ST_EXEC;
          end
        end
        ood_pkg::ST_EXEC: begin
          done_q <= 1'b1;
          illegal_q <= (op == ood_pkg::OP_NONE);
          if (op == ood_pkg::OP_UNCONDITIONAL_HALT ||
              (op == ood_pkg::OP_SELECTIVE_HALT && sel_stop_sw)) begin
            halted_q <= 1'b1;
            state_q <= ood_pkg::ST_HALT;
          end else begin
            ready_q <= 1'b1;
            state_q <= ood_pkg::ST_IDLE;
          end
        end
        ood_pkg::ST_HALT: begin
          // Restart resumes fetch; P already points past the stop
          if (restart) begin
            halted_q <= 1'b0;
            ready_q <= 1'b1;
            state_q <= ood_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= ood_pkg::ST_IDLE;
          ready_q <= 1'b1;
        end
      endcase
    end
  end
  // ****************************************
  // Program counter
  // ****************************************
  // Advanced at execute, so a stop resumes at P + 1
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      p_q <= ood_pkg::RST_ADDR;
    end else if (exec) begin
      if (op == ood_pkg::OP_COMPARE_JUMP_PAIR && take_jump) begin
        p_q <= f.y;
      end else if ((op == ood_pkg::OP_SKIP_IF_EQUAL ||
                    op == ood_pkg::OP_SKIP_IF_NOT_LESS) && take_skip) begin
        p_q <= p_q + 15'h0002;
      end else begin
        p_q <= p_q + 15'h0001;
      end
    end
  end
  // ****************************************
  // Accumulator and Q
  // ****************************************
  // Narrow transfers into A leave its other bits alone
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      a_q <= ood_pkg::RST_WORD;
      q_q <= ood_pkg::RST_WORD;
    end else if (exec) begin
      case (op)
        ood_pkg::OP_LOAD_PAGE_ENTRY: a_q[11:0] <= page_q[pidx];
        ood_pkg::OP_READ_OPERAND_STATE: a_q[2:0] <= op_state_q;
        ood_pkg::OP_READ_INSTRUCTION_STATE: a_q[2:0] <= ins_state_q;
        ood_pkg::OP_ADD_WORD: a_q <= a_q + mem_q;
        ood_pkg::OP_ADD_DOUBLE_WORD: begin
          a_q <= pair_sum[47:24];
          q_q <= pair_sum[23:0];
        end
        ood_pkg::OP_ADD_INDEX_TO_ACC: a_q <= a_q + {9'h000, idx_sel};
        ood_pkg::OP_ADD_Q_TO_ACC: a_q <= a_q + q_q;
        ood_pkg::OP_AND_ACC: a_q <= a_q & y_full;
        ood_pkg::OP_AND_Q: q_q <= q_q & y_full;
        default: a_q <= a_q;
      endcase
    end
  end
  // ****************************************
  // E register
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      e_q <= {ood_pkg::RST_WORD, ood_pkg::RST_WORD};
    end else if (exec) begin
      if (op == ood_pkg::OP_ACC_TO_E_UPPER) begin
        e_q[47:24] <= a_q;
      end else if (op == ood_pkg::OP_PAIR_TO_E) begin
        e_q <= {a_q, q_q};
      end
    end
  end
  // ****************************************
  // Index registers
  // ****************************************
  // Only the AND form writes index registers here
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      idx1_q <= ood_pkg::RST_ADDR;
      idx2_q <= ood_pkg::RST_ADDR;
      idx3_q <= ood_pkg::RST_ADDR;
    end else if (exec && op == ood_pkg::OP_AND_INDEX) begin
      case (f.d1[1:0])
        2'h1: idx1_q <= idx1_q & f.y;
        2'h2: idx2_q <= idx2_q & f.y;
        default: idx3_q <= idx3_q & f.y;
      endcase
    end
  end
  // ****************************************
  // Page file
  // ****************************************
  // Contents are undefined until software writes them
  always_ff @(posedge mclk) begin
    if (exec && op == ood_pkg::OP_STORE_PAGE_ENTRY) begin
      page_q[pidx] <= a_q[11:0];
    end
  end
  // ****************************************
  // State, condition and channel registers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      op_state_q <= ood_pkg::RST_3;
      ins_state_q <= ood_pkg::RST_3;
      cond_reg_q <= ood_pkg::RST_CR;
      chan_idx_q <= ood_pkg::RST_3;
    end else if (exec) begin
      case (op)
        ood_pkg::OP_WRITE_OPERAND_STATE: op_state_q <= a_q[2:0];
        ood_pkg::OP_WRITE_INSTRUCTION_STATE: ins_state_q <= a_q[2:0];
        ood_pkg::OP_WRITE_CONDITION_REG: cond_reg_q <= a_q[5:0];
        ood_pkg::OP_WRITE_CHANNEL_INDEX: chan_idx_q <= a_q[2:0];
        default: chan_idx_q <= chan_idx_q;
      endcase
    end
  end
  // ****************************************
  // Faults and interrupt control
  // ****************************************
  // A set in the same cycle as a clear wins, so no fault is lost
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      float_fault_q <= 1'b0;
      dec_fault_q <= 1'b0;
      int_ctl_q <= ood_pkg::RST_INT;
    end else if (ce) begin
      if (exec && op == ood_pkg::OP_RAISE_FLOAT_FAULT) begin
        float_fault_q <= 1'b1;
      end else if (float_fault_clr) begin
        float_fault_q <= 1'b0;
      end
      if (exec && op == ood_pkg::OP_RAISE_DECIMAL_FAULT) begin
        dec_fault_q <= 1'b1;
      end else if (dec_fault_clr) begin
        dec_fault_q <= 1'b0;
      end
      if (exec && op == ood_pkg::OP_INTERRUPT_CONTROL_OFF) begin
        int_ctl_q <= 1'b0;
      end else if (exec && op == ood_pkg::OP_INTERRUPT_CONTROL_ON) begin
        int_ctl_q <= 1'b1;
      end
    end
  end
  // ****************************************
  // Character field add
  // ****************************************
  // Fields arrive as binary words; storing field C back is left outside
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fld_c_sum_q <= ood_pkg::RST_WORD;
      fld_c_wr_q <= 1'b0;
    end else if (ce) begin
      fld_c_wr_q <= exec && (op == ood_pkg::OP_ADD_CHAR_FIELD);
      if (exec && op == ood_pkg::OP_ADD_CHAR_FIELD) begin
        fld_c_sum_q <= fld_a + fld_c;
      end
    end
  end
endmodule // ood_decoder

// File: shared/ood_pkg.sv
// Constants, field layout, opcodes and types for the octal opcode decoder.
// Assumes a 24-bit word machine; fetch, addressing and storage sit outside.
// How it works
// - 77.64 stores A low twelve in page file
// - 77.65 loads A low twelve from page file
// - 77.66 copies A low three to operand state
// - 77.664 copies A low three to instruction state
// - 77.67/77.674 read state registers into A
// - 77.70 halts on switch, 77.77 always halts
// - Set float/decimal fault, interrupt control off/on
// - 77.634 copies A low six to condition register
// - 77.54 copies A low three to channel index
// - Major 30 adds word, 32 adds double word
// - 67.0 adds field A into field C
// - 55.6 A to upper E, 55.7 AQ to E
// - 53.b4 adds index register b to A
// - 53.04 adds Q to A
// - 03.4-7 jump on A versus Q compare
// - 17.6/17.4 AND into A, 17.1-3 into index
// - 17.7/17.5 AND y into Q
// - 04.6/04.4 skip when A equals y
// - 05.6/05.4 skip when A not less than y
package ood_pkg;

  // ****************************************
  // Widths and field positions
  // ****************************************
  localparam int WORD_W = 24; // Data word
  localparam int ADDR_W = 15; // Address, y operand, index registers
  localparam int PAGE_W = 12; // Page file entry
  localparam int PAGE_DEPTH = 64; // Page file entries
  localparam int PIDX_W = 6; // Page file index
  localparam int MAJ_LSB = 18;
  localparam int D1_LSB = 15;
  localparam int D2_LSB = 12;
  localparam int D3_LSB = 9;

  // ****************************************
  // Major codes (octal value in comment)
  // ****************************************
  localparam logic [5:0] MAJ_CJMP = 6'h03; // 03
  localparam logic [5:0] MAJ_SKEQ = 6'h04; // 04
  localparam logic [5:0] MAJ_SKGE = 6'h05; // 05
  localparam logic [5:0] MAJ_AND = 6'h0f; // 17
  localparam logic [5:0] MAJ_ADDW = 6'h18; // 30
  localparam logic [5:0] MAJ_ADDD = 6'h1a; // 32
  localparam logic [5:0] MAJ_RADD = 6'h2b; // 53
  localparam logic [5:0] MAJ_XFER = 6'h2d; // 55
  localparam logic [5:0] MAJ_CHAR = 6'h37; // 67
  localparam logic [5:0] MAJ_SYS = 6'h3f; // 77

  // ****************************************
  // Two-digit sub codes of major 77
  // ****************************************
  localparam logic [5:0] SUB_CHX = 6'h2c; // 54
  localparam logic [5:0] SUB_CR = 6'h33; // 63 with third digit 4
  localparam logic [5:0] SUB_STPE = 6'h34; // 64
  localparam logic [5:0] SUB_LDPE = 6'h35; // 65
  localparam logic [5:0] SUB_WRST = 6'h36; // 66, 664
  localparam logic [5:0] SUB_RDST = 6'h37; // 67, 674
  localparam logic [5:0] SUB_SHLT = 6'h38; // 70
  localparam logic [5:0] SUB_FFLT = 6'h39; // 71
  localparam logic [5:0] SUB_DFLT = 6'h3a; // 72
  localparam logic [5:0] SUB_IOFF = 6'h3b; // 73
  localparam logic [5:0] SUB_ION = 6'h3c; // 74
  localparam logic [5:0] SUB_UHLT = 6'h3f; // 77
  localparam logic [2:0] D_FOUR = 3'h4; // Trailing digit 4
  localparam logic [2:0] D_ZERO = 3'h0;
  localparam logic [2:0] D_SIX = 3'h6;
  localparam logic [2:0] D_SEVEN = 3'h7;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [WORD_W-1:0] RST_WORD = 24'h000000;
  localparam logic [ADDR_W-1:0] RST_ADDR = 15'h0000;
  localparam logic [2:0] RST_3 = 3'h0;
  localparam logic [5:0] RST_CR = 6'h00;
  localparam logic RST_INT = 1'b0; // Interrupt control off after reset

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [5:0] major;
    logic [2:0] d1;
    logic [2:0] d2;
    logic [2:0] d3;
    logic [ADDR_W-1:0] y;
    logic [PIDX_W-1:0] w;
  } ood_fields_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_EXEC = 3'h2,
    ST_HALT = 3'h4
  } ood_state_t;

  typedef enum logic [4:0] {
    OP_NONE, OP_STORE_PAGE_ENTRY, OP_LOAD_PAGE_ENTRY, OP_WRITE_OPERAND_STATE,
    OP_WRITE_INSTRUCTION_STATE, OP_READ_OPERAND_STATE, OP_READ_INSTRUCTION_STATE,
    OP_SELECTIVE_HALT, OP_UNCONDITIONAL_HALT, OP_RAISE_FLOAT_FAULT,
    OP_RAISE_DECIMAL_FAULT, OP_INTERRUPT_CONTROL_OFF, OP_INTERRUPT_CONTROL_ON,
    OP_WRITE_CONDITION_REG, OP_WRITE_CHANNEL_INDEX, OP_ADD_WORD, OP_ADD_DOUBLE_WORD,
    OP_ADD_CHAR_FIELD, OP_ACC_TO_E_UPPER, OP_PAIR_TO_E, OP_ADD_INDEX_TO_ACC,
    OP_ADD_Q_TO_ACC, OP_COMPARE_JUMP_PAIR, OP_AND_ACC, OP_AND_INDEX, OP_AND_Q,
    OP_SKIP_IF_EQUAL, OP_SKIP_IF_NOT_LESS
  } ood_op_t;

endpackage

// File: testbench/ood_decoder_props.sv
// Checker for the octal opcode decoder, bound to its ports.
// Assumes the bench holds ce high throughout.
`timescale 1ns/1ns
module ood_decoder_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Inputs watched
  input wire logic ce,
  input wire logic instr_valid,
  input wire logic [23:0] instr_word,
  input wire logic [23:0] mem_word,
  // Outputs watched
  input wire logic ready_q,
  input wire logic done_q,
  input wire logic halted_q,
  input wire logic [23:0] a_q,
  input wire logic [23:0] q_q,
  input wire logic [47:0] e_q,
  input wire logic [14:0] p_q,
  input wire logic [2:0] op_state_q,
  input wire logic [5:0] cond_reg_q,
  input wire logic int_ctl_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ****************************************
  // Snapshot of each taken instruction
  // ****************************************
  logic take; // Request accepted this edge
  logic [23:0] iw_h, a_h, q_h, m_h;
  logic [14:0] p_h;
  assign take = ce && instr_valid && ready_q;
  // Held until the next take, which cannot come before done
  always_ff @(posedge mclk) begin
    if (take) begin
      iw_h <= instr_word;
      a_h <= a_q;
      q_h <= q_q;
      m_h <= mem_word;
      p_h <= p_q;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  property p_busy; take |=> !ready_q; endproperty
  a_busy: assert property (p_busy) else $error("ready after take");
  property p_answer; take |=> ##1 (done_q || halted_q); endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_addw; done_q && iw_h[23:18] == 6'h18 |-> a_q == a_h + m_h; endproperty
  a_addw: assert property (p_addw) else $error("add word");
  property p_aqa; done_q && iw_h[23:12] == 12'hac4 |-> a_q == a_h + q_h; endproperty
  a_aqa: assert property (p_aqa) else $error("add q");
  property p_ost;
    done_q && iw_h[23:9] == 15'h7fb0 |-> op_state_q == a_h[2:0];
  endproperty
  a_ost: assert property (p_ost) else $error("operand state");
  property p_cr;
    done_q && iw_h[23:9] == 15'h7f9c |-> cond_reg_q == a_h[5:0];
  endproperty
  a_cr: assert property (p_cr) else $error("condition reg");
  property p_pair; done_q && iw_h[23:15] == 9'h16f |-> e_q == {a_h, q_h}; endproperty
  a_pair: assert property (p_pair) else $error("pair to e");
  property p_jeq;
    done_q && iw_h[23:15] == 9'h01c |->
      p_q == ((a_h == q_h) ? iw_h[14:0] : p_h + 15'h1);
  endproperty
  a_jeq: assert property (p_jeq) else $error("jump equal");
  property p_ion; done_q && iw_h[23:12] == 12'hffc |-> int_ctl_q; endproperty
  a_ion: assert property (p_ion) else $error("interrupt on");
  property p_halt;
    take && instr_word[23:12] == 12'hfff |=> ##1 (halted_q && !ready_q);
  endproperty
  a_halt: assert property (p_halt) else $error("no halt");
  // Main scenarios reached
  c_take: cover property (take);
  c_halt: cover property (halted_q);
  c_jeq: cover property (done_q && iw_h[23:15] == 9'h01c);
endmodule // ood_decoder_props

bind ood_decoder ood_decoder_props i_props (.mclk, .sys_rst, .ce, .instr_valid,
  .instr_word, .mem_word, .ready_q, .done_q, .halted_q, .a_q, .q_q, .e_q, .p_q,
  .op_state_q, .cond_reg_q, .int_ctl_q);

// File: testbench/tb.sv
// Self-checking bench for the octal opcode decoder.
// Assumes one clock; inputs change on the falling edge.
`timescale 1ns/1ns
module tb;
  logic mclk, sys_rst, ce, instr_valid, sel_stop_sw, restart, float_fault_clr, dec_fault_clr;
  logic [23:0] instr_word, mem_word, mem_word_hi, fld_a, fld_c, a_q, q_q, fld_c_sum_q;
  logic ready_q, done_q, illegal_q, halted_q, float_fault_q, dec_fault_q, int_ctl_q;
  logic fld_c_wr_q;
  logic [47:0] e_q;
  logic [14:0] p_q, pexp, idx1_q; // Expected P tracked here
  logic [2:0] op_state_q, ins_state_q, chan_idx_q;
  logic [5:0] cond_reg_q;
  logic ill, wr; // Pulses caught with the answer
  int mismatches, num_checks, cyc;
  ood_decoder i_ood_decoder (.mclk, .sys_rst, .ce, .instr_valid, .instr_word, .mem_word,
    .mem_word_hi, .fld_a, .fld_c, .sel_stop_sw, .restart, .float_fault_clr, .dec_fault_clr,
    .ready_q, .done_q, .illegal_q, .halted_q, .a_q, .q_q, .e_q, .idx1_q, .idx2_q(),
    .idx3_q(), .p_q, .op_state_q, .ins_state_q, .cond_reg_q, .chan_idx_q, .float_fault_q,
    .dec_fault_q, .int_ctl_q, .fld_c_sum_q, .fld_c_wr_q);
  // ****************************************
  // Helpers
  // ****************************************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [47:0] ex, input logic [47:0] got);
    num_checks++;
    if (got !== ex) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Offer one instruction; k: 0 next, 1 skip, 2 jump to y of iw
  task automatic exec(input logic [23:0] iw, input logic [23:0] m, input logic [1:0] k);
    int n;
    n = 0;
    chk("ready", 1, ready_q);
    instr_word = iw;
    mem_word = m;
    mem_word_hi = 24'h000456;
    instr_valid = 1'b1;
    @(negedge mclk);
    instr_valid = 1'b0;
    // Bounded wait for the answer
    while (done_q !== 1'b1 && halted_q !== 1'b1 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    ill = illegal_q;
    wr = fld_c_wr_q;
    pexp = (k == 2'h2) ? iw[14:0] : pexp + {13'h0, k} + 15'h1;
    chk("answer", 1, done_q | halted_q);
    chk("p", pexp, p_q);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_arith;
    exec(24'h680000, 24'h000123, 0);
    chk("a", 24'h000123, a_q);
    chk("q", 24'h000456, q_q);
    exec(24'hacc000, 0, 0);
    chk("a", 24'h000123, a_q);
    exec(24'h3c8000, 0, 0);
    chk("b1", 15'h0000, idx1_q);
    chk("a", 24'h000123, a_q);
    exec(24'h600000, 24'h000001, 0);
    exec(24'hac4000, 0, 0);
    chk("a", 24'h00057a, a_q);
  endtask
  task automatic t_states;
    exec(24'hff6000, 0, 0);
    chk("ost", 3'h2, op_state_q);
    exec(24'hff3800, 0, 0);
    chk("cr", 6'h3a, cond_reg_q);
    exec(24'hfec000, 0, 0);
    chk("chx", 3'h2, chan_idx_q);
    exec(24'hff4005, 0, 0);
    exec(24'h600000, 24'h000003, 0);
    exec(24'hff6800, 0, 0);
    chk("ist", 3'h5, ins_state_q);
    exec(24'hff7000, 0, 0);
    chk("a", 24'h00057a, a_q);
    exec(24'hff7800, 0, 0);
    chk("a", 24'h00057d, a_q);
    exec(24'h600000, 24'h000100, 0);
    exec(24'hff5005, 0, 0);
    chk("a", 24'h00057a, a_q);
  endtask
  task automatic t_e_jump;
    logic [3:0] tk;
    tk = 4'b0110; // A above Q: not equal and not less taken
    exec(24'hb78000, 0, 0);
    chk("e", 48'h00057a000456, e_q);
    exec(24'h600000, 24'h000001, 0);
    exec(24'hb70000, 0, 0);
    chk("e", 48'h00057b000456, e_q);
    for (int d = 0; d < 4; d++) begin
      exec(24'h0e0100 | (24'(d) << 15), 0, tk[d] ? 2'h2 : 2'h0);
    end
  endtask
  task automatic t_skip_and;
    exec(24'h13057b, 0, 1);
    exec(24'h13057c, 0, 0);
    exec(24'h3f00ff, 0, 0);
    chk("a", 24'h00007b, a_q);
    exec(24'h3f8006, 0, 0);
    chk("q", 24'h000006, q_q);
    exec(24'h600000, 24'hffff80, 0);
    exec(24'h127ffb, 0, 1);
    exec(24'h137ffb, 0, 0);
    exec(24'h170001, 0, 0);
    exec(24'h167ff0, 0, 1);
    exec(24'h3e7ff0, 0, 0);
    chk("a", 24'hfffff0, a_q);
    exec(24'h3ec002, 0, 0);
    chk("q", 24'h000002, q_q);
  endtask
  task automatic t_misc;
    fld_a = 24'h000010;
    fld_c = 24'h000022;
    exec(24'hdc0000, 0, 0);
    chk("sum", 24'h000032, fld_c_sum_q);
    chk("wr", 1, wr);
    exec(24'hff9000, 0, 0);
    exec(24'hffa000, 0, 0);
    chk("faults", 2'h3, {float_fault_q, dec_fault_q});
    // Clears held through a set: the set must win
    {float_fault_clr, dec_fault_clr} = 2'h3;
    exec(24'hff9000, 0, 0);
    {float_fault_clr, dec_fault_clr} = 2'h0;
    chk("faults", 2'h2, {float_fault_q, dec_fault_q});
    exec(24'hffc000, 0, 0);
    chk("int", 1, int_ctl_q);
    exec(24'hffb000, 0, 0);
    chk("int", 0, int_ctl_q);
    exec(24'hffd000, 0, 0);
    chk("illegal", 1, ill);
  endtask
  // Stop instructions; restart must release the halt
  task automatic t_halt;
    sel_stop_sw = 1'b0;
    exec(24'hff8000, 0, 0);
    chk("halt", 0, halted_q);
    for (int i = 0; i < 2; i++) begin
      sel_stop_sw = 1'b1;
      exec(i ? 24'hfff000 : 24'hff8000, 0, 0);
      chk("halt", 2'h2, {halted_q, ready_q});
      restart = 1'b1;
      @(negedge mclk);
      restart = 1'b0;
      chk("run", 2'h1, {halted_q, ready_q});
    end
    sel_stop_sw = 1'b0;
  endtask
  // ****************************************
  // Clock, timeout, main sequence
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Whole run needs about 100 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    {sys_rst, ce} = 2'h3;
    {instr_valid, sel_stop_sw, restart, float_fault_clr, dec_fault_clr} = 5'h00;
    {instr_word, mem_word, mem_word_hi, fld_a, fld_c} = '0;
    pexp = 15'h0000;
    repeat (12) @(negedge mclk);
    sys_rst = 1'b0;
    chk("reset", 3'h4, {ready_q, int_ctl_q, halted_q});
    t_arith();
    t_states();
    t_e_jump();
    t_skip_and();
    t_misc();
    t_halt();
    tally_and_finish();
  end
endmodule // tb
